// [hdl/drw_pkg.sv]
package drw_pkg;
   // Register offsets on the software port
   localparam int unsigned DRW_RAW       = 8;
   localparam logic [7:0]  DRW_OFF_PTR   = 8'h00;
   localparam logic [7:0]  DRW_OFF_CTRL  = 8'h10;
   localparam logic [7:0]  DRW_OFF_STAT  = 8'h14;
   localparam logic [7:0]  DRW_OFF_CUR   = 8'h18;

   // Control and status field positions
   localparam int unsigned DRW_C_EN      = 31;
   localparam int unsigned DRW_C_MODE    = 0;
   localparam int unsigned DRW_S_DONE    = 31;
   localparam int unsigned DRW_S_IDONE   = 30;
   localparam int unsigned DRW_S_STALL   = 29;
   localparam int unsigned DRW_S_DIE     = 23;
   localparam int unsigned DRW_S_SIE     = 22;
   localparam int unsigned DRW_S_STATE   = 0;

   // Descriptor field positions
   localparam int unsigned DRW_D_WRAP    = 31;
   localparam int unsigned DRW_D_INTR    = 30;
   localparam int unsigned DRW_D_LAST    = 29;
   localparam int unsigned DRW_D_PTRW    = 29;
   localparam int unsigned DRW_D_STS     = 16;
   localparam int unsigned DRW_D_FULL    = 15;
   localparam int unsigned DRW_D_LENW    = 15;

   // Ring geometry
   localparam logic [31:0] DRW_WORD      = 32'h0000_0004;
   localparam logic [31:0] DRW_FB_STEP   = 32'h0000_0008;
   localparam logic [31:0] DRW_MM_STEP   = 32'h0000_0010;
   localparam int unsigned DRW_RING_BITS = 10;

   // Reset values
   localparam logic [31:0] DRW_RST_PTR   = 32'h0000_0000;
   localparam logic [31:0] DRW_RST_WORD  = 32'h0000_0000;

   typedef enum logic [1:0] {
      DRW_MODE_TX  = 2'b00,
      DRW_MODE_RX  = 2'b01,
      DRW_MODE_MM  = 2'b10,
      DRW_MODE_OFF = 2'b11
   } drw_mode_t;

   typedef enum logic [3:0] {
      S_IDLE   = 4'h0,
      S_FETCH0 = 4'h1,
      S_FETCH1 = 4'h2,
      S_FETCH2 = 4'h3,
      S_CHECK  = 4'h4,
      S_STALL  = 4'h5,
      S_TXRD   = 4'h6,
      S_TXSND  = 4'h7,
      S_RXWT   = 4'h8,
      S_RXWR   = 4'h9,
      S_MMRD   = 4'hA,
      S_MMWR   = 4'hB,
      S_WBACK  = 4'hC,
      S_NEXT   = 4'hD
   } drw_state_t;
endpackage

// [hdl/drw_beat.sv]
module drw_beat (
   input  wire logic [1:0]  off_i,
   input  wire logic [14:0] rem_i,
   output logic      [2:0]  bytes_o,
   output logic      [3:0]  be_o
);
   import drw_pkg::*;

   logic [2:0] room;
   logic [7:0] mask;

   // Bytes left in the current word, capped by what remains
   always_comb begin
      room = 3'h4 - {1'b0, off_i};
      if (rem_i < {12'h000, room}) begin
         bytes_o = rem_i[2:0];
      end else begin
         bytes_o = room;
      end
      mask = 8'((8'h01 << bytes_o) - 8'h01);
      mask = 8'(mask << off_i);
      be_o = mask[3:0];
   end
endmodule

// [hdl/drw_next_addr.sv]
module drw_next_addr (
   input  wire logic [31:0] cur_i,
   input  wire logic [31:0] base_i,
   input  wire logic        wrap_i,
   input  wire logic        mm_i,
   output logic      [31:0] next_o
);
   import drw_pkg::*;

   logic [31:0] step;

   always_comb begin
      step = mm_i ? DRW_MM_STEP : DRW_FB_STEP;
      next_o = cur_i + step;
      // Leaving the 1 KiB region means the ring is exhausted
      if (wrap_i) begin
         next_o = base_i;
      end else if (next_o[31:DRW_RING_BITS]
                   != cur_i[31:DRW_RING_BITS]) begin
         next_o = base_i;
      end
   end
endmodule

// [hdl/drw_top.sv]
// Overview of operation
// - Channel idle until enable bit set
// - First fetch from descriptor pointer register
// - Fly-by two words, copy three, aligned
// - Return to first at 1 KiB boundary
// - Wrap flag returns to original pointer
// - No wrap: next at fixed offset
// - Ring of 128 fly-by or 64 copy
// - Descriptor flag forces completion interrupt
// - Last flag signals end of frame
// - Fill sets full flag, empty clears
// - Never fill full, never empty empty
// - Blocked descriptor raises maskable interrupt
// - Copy starts only with full flag set
// - Write peripheral status on completion; copy writes zero status
// - Send writes back bytes moved
// - Copy writes back bytes remaining
// - Copy holds word, read then write
module drw_top (
   input  wire logic                       ref_clk_i,
   input  wire logic                       sys_rst_i,
   input  wire logic [drw_pkg::DRW_RAW-1:0] reg_addr_i,
   input  wire logic [31:0]                reg_wdata_i,
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   output logic      [31:0]                reg_rdata_o,
   output logic                            mem_req_o,
   output logic                            mem_we_o,
   output logic      [31:0]                mem_addr_o,
   output logic      [31:0]                mem_wdata_o,
   output logic      [3:0]                 mem_be_o,
   input  wire logic                       mem_ack_i,
   input  wire logic [31:0]                mem_rdata_i,
   output logic                            per_tx_valid_o,
   output logic      [31:0]                per_tx_data_o,
   output logic      [2:0]                 per_tx_bytes_o,
   output logic      [1:0]                 per_tx_off_o,
   input  wire logic                       per_tx_ready_i,
   input  wire logic                       per_rx_valid_i,
   input  wire logic [31:0]                per_rx_data_i,
   input  wire logic [2:0]                 per_rx_bytes_i,
   input  wire logic                       per_rx_last_i,
   output logic                            per_rx_ready_o,
   input  wire logic [15:0]                per_status_i,
   output logic                            per_eof_o,
   output logic                            irq_o
);
   import drw_pkg::*;

   drw_state_t  state_q, state_d;
   drw_mode_t   mode_q;
   logic        ce_q, die_q, sie_q;
   logic [31:0] ptr_q, cur_q, src_q, dst_q, tmp_q, rdata_q;
   logic        wrap_q, intr_q, last_q, full_q;
   logic [14:0] len_q, cnt_q;
   logic [15:0] stat_q;
   logic        done_q, idone_q, stall_q, eof_q;
   logic        rxlast_q;
   logic [2:0]  rxb_q;
   logic [3:0]  rxbe_q;

   logic        mm, desc_ok, stat_wr, close_evt;
   logic [14:0] rem, rx_rem, tx_cnt_nx, rx_cnt_nx;
   logic [2:0]  beat_b, rx_b;
   logic [3:0]  beat_be, rx_be;
   logic [31:0] next_addr;

   assign mm        = (mode_q == DRW_MODE_MM);
   assign rem       = len_q - cnt_q;
   assign tx_cnt_nx = cnt_q + {12'h000, beat_b};
   assign rx_cnt_nx = cnt_q + {12'h000, rxb_q};
   assign stat_wr   = reg_wr_i && (reg_addr_i == DRW_OFF_STAT);
   assign close_evt = (state_q == S_WBACK) && mem_ack_i;
   // Receive fills an empty buffer; send and copy need it full
   assign desc_ok   = (mode_q == DRW_MODE_RX) ? !full_q : full_q;
   // Never accept more than the buffer still holds
   assign rx_rem    = (rem < {12'h000, per_rx_bytes_i}) ? rem
                      : {12'h000, per_rx_bytes_i};

   drw_beat u_tx_beat (
      .off_i   (src_q[1:0]),
      .rem_i   (rem),
      .bytes_o (beat_b),
      .be_o    (beat_be)
   );

   drw_beat u_rx_beat (
      .off_i   (2'b00),
      .rem_i   (rx_rem),
      .bytes_o (rx_b),
      .be_o    (rx_be)
   );

   drw_next_addr u_next (
      .cur_i  (cur_q),
      .base_i (ptr_q),
      .wrap_i (wrap_q),
      .mm_i   (mm),
      .next_o (next_addr)
   );

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         S_IDLE: begin
            if (ce_q && mode_q != DRW_MODE_OFF) begin
               state_d = S_FETCH0;
            end
         end
         S_FETCH0: if (mem_ack_i) state_d = S_FETCH1;
         S_FETCH1: begin
            if (mem_ack_i) begin
               state_d = mm ? S_FETCH2 : S_CHECK;
            end
         end
         S_FETCH2: if (mem_ack_i) state_d = S_CHECK;
         S_CHECK: begin
            if (!desc_ok) begin
               state_d = S_STALL;
            end else if (len_q == 15'h0000) begin
               state_d = S_WBACK;
            end else if (mode_q == DRW_MODE_RX) begin
               state_d = S_RXWT;
            end else if (mm) begin
               state_d = S_MMRD;
            end else begin
               state_d = S_TXRD;
            end
         end
         S_STALL: if (stat_wr) state_d = S_FETCH0;
         S_TXRD: if (mem_ack_i) state_d = S_TXSND;
         S_TXSND: begin
            if (per_tx_ready_i) begin
               state_d = (tx_cnt_nx == len_q) ? S_WBACK : S_TXRD;
            end
         end
         S_RXWT: if (per_rx_valid_i) state_d = S_RXWR;
         S_RXWR: begin
            if (mem_ack_i) begin
               state_d = (rxlast_q || rx_cnt_nx == len_q) ? S_WBACK
                         : S_RXWT;
            end
         end
         S_MMRD: if (mem_ack_i) state_d = S_MMWR;
         S_MMWR: begin
            if (mem_ack_i) begin
               state_d = (tx_cnt_nx == len_q) ? S_WBACK : S_MMRD;
            end
         end
         S_WBACK: if (mem_ack_i) state_d = S_NEXT;
         S_NEXT: state_d = S_FETCH0;
         default: state_d = S_IDLE;
      endcase
      // Dropping the enable abandons the ring at once
      if (!ce_q) begin
         state_d = S_IDLE;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state_q <= S_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Software-written configuration
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ptr_q  <= DRW_RST_PTR;
         ce_q   <= 1'b0;
         mode_q <= DRW_MODE_TX;
         die_q  <= 1'b0;
         sie_q  <= 1'b0;
      end else if (reg_wr_i) begin
         if (reg_addr_i == DRW_OFF_PTR) begin
            ptr_q <= reg_wdata_i;
         end
         if (reg_addr_i == DRW_OFF_CTRL) begin
            ce_q   <= reg_wdata_i[DRW_C_EN];
            mode_q <= drw_mode_t'(reg_wdata_i[DRW_C_MODE +: 2]);
         end
         if (stat_wr) begin
            die_q <= reg_wdata_i[DRW_S_DIE];
            sie_q <= reg_wdata_i[DRW_S_SIE];
         end
      end
   end

   // Descriptor walk
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         cur_q  <= DRW_RST_WORD;
         wrap_q <= 1'b0;
         intr_q <= 1'b0;
         last_q <= 1'b0;
         full_q <= 1'b0;
         len_q  <= 15'h0000;
         src_q  <= DRW_RST_WORD;
         dst_q  <= DRW_RST_WORD;
      end else begin
         if (state_q == S_IDLE) begin
            cur_q <= ptr_q;
         end
         if (state_q == S_NEXT) begin
            cur_q <= next_addr;
         end
         if (state_q == S_FETCH0 && mem_ack_i) begin
            wrap_q <= mem_rdata_i[DRW_D_WRAP];
            intr_q <= mem_rdata_i[DRW_D_INTR];
            last_q <= mem_rdata_i[DRW_D_LAST];
            src_q  <= {3'b000, mem_rdata_i[DRW_D_PTRW-1:0]};
         end
         if ((state_q == S_FETCH1 && !mm) || state_q == S_FETCH2) begin
            if (mem_ack_i) begin
               full_q <= mem_rdata_i[DRW_D_FULL];
               len_q  <= mem_rdata_i[DRW_D_LENW-1:0];
            end
         end
         if (state_q == S_FETCH1 && mm && mem_ack_i) begin
            dst_q <= mem_rdata_i;
         end
         // Any source byte is allowed when sending
         if ((state_q == S_TXSND && per_tx_ready_i) ||
             (state_q == S_MMWR && mem_ack_i)) begin
            src_q <= src_q + {29'h0, beat_b};
            dst_q <= dst_q + {29'h0, beat_b};
         end
         if (state_q == S_RXWR && mem_ack_i) begin
            src_q <= src_q + DRW_WORD;
         end
      end
   end

   // Data path, byte count and peripheral status
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         cnt_q    <= 15'h0000;
         tmp_q    <= DRW_RST_WORD;
         stat_q   <= 16'h0000;
         rxlast_q <= 1'b0;
         rxb_q    <= 3'h0;
         rxbe_q   <= 4'h0;
      end else begin
         if (state_q == S_FETCH0) begin
            cnt_q <= 15'h0000;
         end
         if ((state_q == S_TXRD || state_q == S_MMRD) && mem_ack_i) begin
            tmp_q <= mem_rdata_i;
         end
         if ((state_q == S_TXSND && per_tx_ready_i) ||
             (state_q == S_MMWR && mem_ack_i)) begin
            cnt_q <= tx_cnt_nx;
         end
         if (state_q == S_RXWT && per_rx_valid_i) begin
            tmp_q    <= per_rx_data_i;
            rxb_q    <= rx_b;
            rxbe_q   <= rx_be;
            rxlast_q <= per_rx_last_i;
         end
         if (state_q == S_RXWR && mem_ack_i) begin
            cnt_q <= rx_cnt_nx;
         end
         if (state_d == S_WBACK && state_q != S_WBACK) begin
            stat_q <= mm ? 16'h0000 : per_status_i;
         end
      end
   end

   // Sticky event flags and end-of-frame pulse; a new event beats a clear in the same cycle
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         done_q  <= 1'b0;
         idone_q <= 1'b0;
         stall_q <= 1'b0;
         eof_q   <= 1'b0;
      end else begin
         if (stat_wr && reg_wdata_i[DRW_S_DONE]) done_q <= 1'b0;
         if (stat_wr && reg_wdata_i[DRW_S_IDONE]) idone_q <= 1'b0;
         if (stat_wr && reg_wdata_i[DRW_S_STALL]) stall_q <= 1'b0;
         if (close_evt && !intr_q) done_q <= 1'b1;
         if (close_evt && intr_q) idone_q <= 1'b1;
         if (state_q == S_CHECK && !desc_ok) begin
            stall_q <= 1'b1;
         end
         eof_q <= close_evt && last_q;
      end
   end

   // Descriptor-forced completion ignores the completion mask
   assign irq_o = (done_q && die_q) || idone_q ||
                  (stall_q && sie_q);

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rdata_q <= DRW_RST_WORD;
      end else begin
         rdata_q <= DRW_RST_WORD;
         if (reg_rd_i) begin
            unique case (reg_addr_i)
               DRW_OFF_PTR:  rdata_q <= ptr_q;
               DRW_OFF_CTRL: begin
                  rdata_q[DRW_C_EN]        <= ce_q;
                  rdata_q[DRW_C_MODE +: 2] <= mode_q;
               end
               DRW_OFF_STAT: begin
                  rdata_q[DRW_S_DONE]       <= done_q;
                  rdata_q[DRW_S_IDONE]      <= idone_q;
                  rdata_q[DRW_S_STALL]      <= stall_q;
                  rdata_q[DRW_S_DIE]        <= die_q;
                  rdata_q[DRW_S_SIE]        <= sie_q;
                  rdata_q[DRW_S_STATE +: 4] <= state_q;
               end
               DRW_OFF_CUR:  rdata_q <= cur_q;
               default:      rdata_q <= DRW_RST_WORD;
            endcase
         end
      end
   end

   // Memory master; request held until acknowledged
   always_comb begin
      mem_req_o   = 1'b0;
      mem_we_o    = 1'b0;
      mem_addr_o  = cur_q;
      mem_wdata_o = tmp_q;
      mem_be_o    = 4'hF;
      unique case (state_q)
         S_FETCH0: mem_req_o = 1'b1;
         S_FETCH1: begin
            mem_req_o  = 1'b1;
            mem_addr_o = cur_q + DRW_WORD;
         end
         S_FETCH2: begin
            mem_req_o  = 1'b1;
            mem_addr_o = cur_q + DRW_WORD + DRW_WORD;
         end
         S_TXRD, S_MMRD: begin
            mem_req_o  = 1'b1;
            mem_addr_o = {src_q[31:2], 2'b00};
         end
         S_RXWR: begin
            mem_req_o  = 1'b1;
            mem_we_o   = 1'b1;
            mem_addr_o = {src_q[31:2], 2'b00};
            mem_be_o   = rxbe_q;
         end
         S_MMWR: begin
            mem_req_o  = 1'b1;
            mem_we_o   = 1'b1;
            mem_addr_o = {dst_q[31:2], 2'b00};
            mem_be_o   = beat_be;
         end
         S_WBACK: begin
            mem_req_o  = 1'b1;
            mem_we_o   = 1'b1;
            mem_addr_o = cur_q + (mm ? DRW_FB_STEP : DRW_WORD);
            mem_wdata_o[31:DRW_D_STS] = stat_q;
            mem_wdata_o[DRW_D_FULL] = (mode_q == DRW_MODE_RX);
            if (mm) begin
               mem_wdata_o[DRW_D_LENW-1:0] = rem;
            end else begin
               mem_wdata_o[DRW_D_LENW-1:0] = cnt_q;
            end
         end
         default: mem_req_o = 1'b0;
      endcase
   end

   assign per_tx_valid_o = (state_q == S_TXSND);
   assign per_tx_data_o  = tmp_q;
   assign per_tx_bytes_o = beat_b;
   assign per_tx_off_o   = src_q[1:0];
   assign per_rx_ready_o = (state_q == S_RXWT);
   assign per_eof_o      = eof_q;
   assign reg_rdata_o    = rdata_q;

   sequence s_start;
      state_q == S_IDLE ##0 ce_q && mode_q != DRW_MODE_OFF;
   endsequence

   sequence s_close;
      state_q == S_WBACK && mem_ack_i && ce_q;
   endsequence

   property p_idle_quiet;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      !ce_q |=> !mem_req_o && !per_rx_ready_o;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("channel active while disabled");

   property p_first_fetch;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      s_start |=> mem_req_o && !mem_we_o && mem_addr_o == $past(ptr_q);
   endproperty
   a_first_fetch: assert property (p_first_fetch)
      else $error("first fetch not from descriptor pointer");

   property p_wrap;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      state_q == S_NEXT && wrap_q |=> cur_q == $past(ptr_q);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("wrap did not return to pointer");

   property p_step;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      state_q == S_NEXT && !wrap_q && !mm && cur_q[9:3] != 7'h7F
      |=> cur_q == $past(cur_q) + 32'h0000_0008;
   endproperty
   a_step: assert property (p_step)
      else $error("fly-by step not eight bytes");

   property p_boundary;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      state_q == S_NEXT && !wrap_q && mm && cur_q[9:4] == 6'h3F
      |=> cur_q == $past(ptr_q);
   endproperty
   a_boundary: assert property (p_boundary)
      else $error("ring did not close at 1 KiB boundary");

   property p_stall;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      state_q == S_CHECK && !desc_ok && ce_q
      |=> state_q == S_STALL && stall_q ##1 !mem_req_o;
   endproperty
   a_stall: assert property (p_stall)
      else $error("blocked descriptor not flagged");

   property p_no_fill_full;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      state_q == S_RXWT || state_q == S_RXWR |-> !full_q;
   endproperty
   a_no_fill_full: assert property (p_no_fill_full)
      else $error("filling a full buffer");

   property p_forced_irq;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      s_close ##0 intr_q |=> irq_o && idone_q;
   endproperty
   a_forced_irq: assert property (p_forced_irq)
      else $error("descriptor interrupt missing");

   property p_eof;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      s_close ##0 last_q |=> per_eof_o ##1 !per_eof_o;
   endproperty
   a_eof: assert property (p_eof)
      else $error("end of frame not pulsed");

   property p_copy_pair;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      state_q == S_MMRD && mem_ack_i && ce_q
      |=> mem_we_o && mem_wdata_o == $past(mem_rdata_i);
   endproperty
   a_copy_pair: assert property (p_copy_pair)
      else $error("copy read not followed by write");

   property p_full_wb;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      state_q == S_WBACK && !mm
      |-> mem_wdata_o[15] == (mode_q == DRW_MODE_RX);
   endproperty
   a_full_wb: assert property (p_full_wb)
      else $error("full flag written back wrong");
endmodule

// [tb/drw_mem_model.sv]
module drw_mem_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        req_i,
   input  wire logic        we_i,
   input  wire logic [31:0] addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic [3:0]  be_i,
   input  wire logic        slow_i,
   output logic             ack_o,
   output logic      [31:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // One 1 KiB window; every address aliases into it
   logic [31:0] mem [0:255];
   // Slow cycles stretch the wait; idle read data toggles
   always @(posedge clk_i) begin
      if (rst_i || !req_i || ack_o || slow_i) begin
         ack_o   <= 1'b0;
         rdata_o <= ~rdata_o;
      end else begin
         ack_o <= 1'b1;
         if (we_i) begin
            for (int b = 0; b < 4; b++)
               if (be_i[b]) mem[addr_i[9:2]][b*8 +: 8] <= wdata_i[b*8 +: 8];
         end else begin
            rdata_o <= mem[addr_i[9:2]];
         end
      end
   end
endmodule

// [tb/testbench.sv]
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import drw_pkg::*;
   logic        clk, rst, wr, rd, ack, slow, txr, rxv, rxr;
   logic [7:0]  addr;
   logic [31:0] wdat, rdat, v;
   logic [31:0] lf = 32'h08DE;
   logic        req, we, txv, eof, irq;
   logic [31:0] maddr, mwd, mrd, txd;
   logic [3:0]  be;
   logic [2:0]  txb;
   logic [1:0]  txo;
   logic [15:0] stat;
   logic [63:0] log[$], txq[$];
   logic [31:0] rxq[$];
   int          fail_count, check_count, eofs;
   drw_top drw_top_i (.ref_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr),
      .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
      .mem_req_o(req), .mem_we_o(we), .mem_addr_o(maddr), .mem_wdata_o(mwd),
      .mem_be_o(be), .mem_ack_i(ack), .mem_rdata_i(mrd),
      .per_tx_valid_o(txv), .per_tx_data_o(txd), .per_tx_bytes_o(txb),
      .per_tx_off_o(txo), .per_tx_ready_i(txr), .per_rx_valid_i(rxv),
      .per_rx_data_i(lf), .per_rx_bytes_i(3'h4), .per_rx_last_i(1'b0),
      .per_rx_ready_o(rxr), .per_status_i(stat), .per_eof_o(eof),
      .irq_o(irq));
   drw_mem_model drw_mem_model_i (.clk_i(clk), .rst_i(rst), .req_i(req),
      .we_i(we), .addr_i(maddr), .wdata_i(mwd), .be_i(be), .slow_i(slow),
      .ack_o(ack), .rdata_o(mrd));
   function automatic logic [31:0] nxt(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Expected writeback word: status, full flag, length
   function automatic logic [31:0] wb(input logic f, input logic [14:0] n);
      return {stat, f, n};
   endfunction
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdat <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdat;
   endtask
   task automatic wait_log(input int n);
      for (int i = 0; i < 2000 && log.size() < n; i++) @(posedge clk);
      repeat (8) @(posedge clk);
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   // Random stalls on memory and peripheral from the bench LFSR
   always @(posedge clk) begin
      lf <= nxt(lf);
      txr <= lf[0];
      slow <= lf[3];
      rxv <= lf[5];
      if (rxv === 1'b1 && rxr === 1'b1) rxq.push_back(lf);
      if (req === 1'b1 && ack === 1'b1) log.push_back({we, maddr});
      if (txv === 1'b1 && txr === 1'b1) txq.push_back({txd, txb, txo});
      if (eof === 1'b1) eofs++;
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      tally_and_finish;
   end
   initial begin
      {wr, rd, addr, wdat} = '0;
      rst = 1'b1;
      stat = 16'hC3A5;
      for (int i = 0; i < 256; i++) drw_mem_model_i.mem[i] = nxt(i * 977);
      drw_mem_model_i.mem[64] = 32'h4000_0040;
      drw_mem_model_i.mem[65] = 32'h0000_8004;
      drw_mem_model_i.mem[66] = 32'hA000_0045;
      drw_mem_model_i.mem[67] = 32'h0000_8003;
      drw_mem_model_i.mem[252] = 32'h0000_0060;
      drw_mem_model_i.mem[253] = 32'h0000_0080;
      drw_mem_model_i.mem[254] = 32'h0000_8004;
      drw_mem_model_i.mem[128] = 32'h8000_00C0;
      drw_mem_model_i.mem[129] = 32'h0000_0006;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rreg(DRW_OFF_PTR, v);
      chk(v, 0);
      rreg(8'h20, v);
      chk(v, 0);
      wreg(DRW_OFF_PTR, 32'h100);
      repeat (6) @(posedge clk);
      chk(log.size(), 0);
      wreg(DRW_OFF_CTRL, 32'h8000_0000 | DRW_MODE_TX);
      wait_log(10);
      chk(log[5], 64'h10C);
      chk(log[0], 64'h100);
      chk(log[1], 64'h104);
      chk(log[2], 64'h40);
      chk(log[3], 64'h1_0000_0104);
      chk(log[4], 64'h108);
      chk(log[6], 64'h44);
      chk(log[7], 64'h1_0000_010C);
      chk(log[8], 64'h100);
      chk(drw_mem_model_i.mem[65], wb(1'b0, 15'd4));
      chk(drw_mem_model_i.mem[67], wb(1'b0, 15'd3));
      chk(txq[0], {drw_mem_model_i.mem[16], 3'd4, 2'd0});
      chk(txq[1], {drw_mem_model_i.mem[17], 3'd3, 2'd1});
      chk(eofs, 1);
      chk(irq, 1'b1);
      rreg(DRW_OFF_STAT, v);
      chk(v[DRW_S_STALL], 1'b1);
      wreg(DRW_OFF_STAT, 32'h6040_0000);
      wait_log(log.size() + 2);
      chk(irq, 1'b1);
      wreg(DRW_OFF_STAT, 32'h6000_0000);
      repeat (8) @(posedge clk);
      chk(irq, 1'b0);
      wreg(DRW_OFF_CTRL, 32'h0);
      wreg(DRW_OFF_STAT, 32'h6000_0000);
      wreg(DRW_OFF_PTR, 32'h3F0);
      log.delete();
      wreg(DRW_OFF_CTRL, 32'h8000_0000 | DRW_MODE_MM);
      wait_log(9);
      chk(log[3], 64'h60);
      chk(log[4], 64'h1_0000_0080);
      chk(log[5], 64'h1_0000_03F8);
      chk(log[6], 64'h3F0);
      chk(drw_mem_model_i.mem[32], drw_mem_model_i.mem[24]);
      chk(drw_mem_model_i.mem[254][15:0], 16'h0000);
      rreg(DRW_OFF_STAT, v);
      chk(v[DRW_S_STALL], 1'b1);
      // Receive into an aligned buffer, capped at its capacity
      wreg(DRW_OFF_CTRL, 32'h0);
      wreg(DRW_OFF_STAT, 32'h6000_0000);
      wreg(DRW_OFF_PTR, 32'h200);
      log.delete();
      wreg(DRW_OFF_CTRL, 32'h8000_0000 | DRW_MODE_RX);
      wait_log(7);
      chk(log[2], 64'h1_0000_00C0);
      chk(log[3], 64'h1_0000_00C4);
      chk(log[4], 64'h1_0000_0204);
      chk(log[5], 64'h200);
      chk(drw_mem_model_i.mem[48], rxq[0]);
      v = nxt(49 * 977);
      chk(drw_mem_model_i.mem[49], {v[31:16], rxq[1][15:0]});
      chk(drw_mem_model_i.mem[129], wb(1'b1, 15'd6));
      chk(rxq.size(), 2);
      rreg(DRW_OFF_STAT, v);
      chk(v[DRW_S_STALL], 1'b1);
      tally_and_finish;
   end
endmodule
